// ===== verilog/tla_pkg.sv
// constants shared by the terminal line adapter
package tla_pkg;
    localparam int unsigned CLK_FREQ_HZ = 250_000_000;
    localparam int unsigned BIT_RATE_HZ = 250_000;
    localparam logic [15:0] BIT_DIV = 16'(CLK_FREQ_HZ / BIT_RATE_HZ);
    localparam logic [15:0] HALF_DIV = 16'(CLK_FREQ_HZ / BIT_RATE_HZ / 2);
    localparam int unsigned CODE_W = 7;
    localparam int unsigned OUT_W = 8;
    localparam logic [3:0] TX_LAST_BIT = 4'hA;
    localparam logic [3:0] TX_STOP_BIT = 4'h9;
    localparam logic [3:0] RX_LAST_BIT = 4'h9;
    localparam logic [6:0] ADDR_IO = 7'h31;
    localparam logic [6:0] ADDR_PUNCH = 7'h32;
    localparam logic [7:0] CODE_PRN_ON = 8'h12;
    localparam logic [7:0] CODE_PRN_OFF = 8'h14;
    localparam logic [6:0] CODE_STX = 7'h02;
    localparam logic [6:0] CODE_ETX = 7'h03;
    localparam int unsigned ST_FAULT = 0;
    localparam int unsigned ST_LOAD = 1;
    localparam int unsigned ST_SERVICE_REQUEST_FLAG = 2;
    typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SHIFT = 2'b01} tla_tx_state_t;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10
    } tla_rx_state_t;
    typedef enum logic [1:0] {
        SRC_DATA = 2'b00, SRC_ON = 2'b01, SRC_OFF = 2'b10
    } tla_src_t;
endpackage : tla_pkg

// ===== verilog/tla_buf2.sv
// two-entry valid/ready buffer
`timescale 1ns/100ps
`default_nettype none
module tla_buf2 #(
    parameter int unsigned W = 7
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [W-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [W-1:0] out_data_out
);
    import tla_pkg::*;
    logic [W-1:0] mem_ff [2];
    logic [W-1:0] nxt_mem [2];
    logic wr_ff, rd_ff, nxt_wr, nxt_rd;
    logic [1:0] cnt_ff, nxt_cnt;
    logic push, pop;

    assign in_ready_out = (cnt_ff != 2'h2);
    assign out_valid_out = (cnt_ff != 2'h0);
    assign out_data_out = mem_ff[rd_ff];

    always_comb begin
        push = in_valid_in && in_ready_out;
        pop = out_valid_out && out_ready_in;
        nxt_mem[0] = mem_ff[0];
        nxt_mem[1] = mem_ff[1];
        if (push) begin
            nxt_mem[wr_ff] = in_data_in;
        end
        nxt_wr = push ? !wr_ff : wr_ff;
        nxt_rd = pop ? !rd_ff : rd_ff;
        nxt_cnt = cnt_ff + 2'(push) - 2'(pop);
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mem_ff[0] <= '0;
            mem_ff[1] <= '0;
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            cnt_ff <= 2'h0;
        end else begin
            mem_ff[0] <= nxt_mem[0];
            mem_ff[1] <= nxt_mem[1];
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    buf_bound_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        cnt_ff <= 2'h2) else $error("buffer count out of range");
endmodule : tla_buf2
`default_nettype wire

// ===== verilog/tla_adapter.sv
// terminal line adapter: line unit handshake and serial terminal link
// Operation
// RULE_01: line unit characters are seven code plus parity
// RULE_02: serial frame: start, code, parity, two stops
// RULE_03: mark is one, space is zero
// RULE_04: send printer-on code before every write
// RULE_05: seven input lines, eight output lines
// RULE_06: answer address compare with device present
// RULE_07: line unit flags control operations; the adapter ignores control_op_in
// RULE_08: service request clear resets its flag
// RULE_09: output strobe loads the output register
// RULE_10: acknowledge the accepted output character
// RULE_11: line unit holds read and write flags
// RULE_12: request answered by input gate with character
// RULE_13: status request answered with status character
// RULE_14: status reset clears all status flags
// RULE_15: fault, load, service request are levels
// RULE_16: power-on reset idles the line unit
// RULE_17: acknowledge only after serial shift completes
// RULE_18: local mode holds fault, blocks input loading
// RULE_19: status at write end: printer-off, then status
// RULE_20: bit period from parameter divide counter
// RULE_21: sample serial input at bit middle
`timescale 1ns/100ps
`default_nettype none
module tla_adapter (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic comp_addr_in,
    input wire logic [tla_pkg::CODE_W-1:0] select_char_in,
    input wire logic control_op_in,
    input wire logic read_op_in,
    input wire logic write_op_in,
    input wire logic service_request_clear_in,
    input wire logic output_char_strobe_in,
    input wire logic [tla_pkg::OUT_W-1:0] out_data_in,
    input wire logic request_in,
    input wire logic status_req_in,
    input wire logic status_reset_in,
    input wire logic local_mode_in,
    input wire logic serial_in,
    output logic device_present_out,
    output logic output_accept_ack_out,
    output logic input_char_gate_out,
    output logic [tla_pkg::CODE_W-1:0] in_data_out,
    output logic status_valid_out,
    output logic [tla_pkg::CODE_W-1:0] status_char_out,
    output logic fault_out,
    output logic load_out,
    output logic service_request_flag_out,
    output logic serial_out
);
    import tla_pkg::*;

    // serial input synchroniser [RULE_03]
    logic rx_meta_ff, rx_sync_ff;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_meta_ff <= 1'b1;
            rx_sync_ff <= 1'b1;
        end else begin
            rx_meta_ff <= serial_in;
            rx_sync_ff <= rx_meta_ff;
        end
    end

    // receiver
    tla_rx_state_t rx_state_ff, nxt_rx_state;
    logic [15:0] rx_cnt_ff, nxt_rx_cnt;
    logic [3:0] rx_bit_ff, nxt_rx_bit;
    logic [9:0] rx_sh_ff, nxt_rx_sh;
    logic hold_valid_ff, nxt_hold_valid;
    logic [CODE_W-1:0] hold_data_ff, nxt_hold_data;
    logic rx_done_ff, nxt_rx_done;
    logic buf_in_ready, buf_out_valid, buf_pop;
    logic [CODE_W-1:0] buf_out_data;

    always_comb begin
        nxt_rx_state = rx_state_ff;
        nxt_rx_cnt = rx_cnt_ff + 16'h0001;
        nxt_rx_bit = rx_bit_ff;
        nxt_rx_sh = rx_sh_ff;
        nxt_rx_done = 1'b0;
        nxt_hold_data = hold_data_ff;
        nxt_hold_valid = hold_valid_ff && !buf_in_ready;
        case (rx_state_ff)
            RX_IDLE: begin
                nxt_rx_cnt = 16'h0000;
                if (!rx_sync_ff) begin
                    nxt_rx_state = RX_START;
                end
            end
            RX_START: begin
                if (rx_cnt_ff == HALF_DIV - 16'h0001) begin // [RULE_21]
                    nxt_rx_cnt = 16'h0000;
                    nxt_rx_bit = 4'h0;
                    nxt_rx_state = rx_sync_ff ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_cnt_ff == BIT_DIV - 16'h0001) begin // [RULE_20]
                    nxt_rx_cnt = 16'h0000;
                    nxt_rx_sh = {rx_sync_ff, rx_sh_ff[9:1]};
                    nxt_rx_bit = rx_bit_ff + 4'h1;
                    if (rx_bit_ff == RX_LAST_BIT) begin
                        nxt_rx_state = RX_IDLE;
                        // both stop marks needed, else a break [RULE_02]
                        if (nxt_rx_sh[9:8] == 2'b11) begin
                            nxt_rx_done = 1'b1;
                            nxt_hold_valid = 1'b1;
                            nxt_hold_data = nxt_rx_sh[CODE_W-1:0];
                        end
                    end
                end
            end
            default: begin
                nxt_rx_state = RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_state_ff <= RX_IDLE;
            rx_cnt_ff <= 16'h0000;
            rx_bit_ff <= 4'h0;
            rx_sh_ff <= 10'h000;
            hold_valid_ff <= 1'b0;
            hold_data_ff <= 7'h00;
            rx_done_ff <= 1'b0;
        end else begin
            rx_state_ff <= nxt_rx_state;
            rx_cnt_ff <= nxt_rx_cnt;
            rx_bit_ff <= nxt_rx_bit;
            rx_sh_ff <= nxt_rx_sh;
            hold_valid_ff <= nxt_hold_valid;
            hold_data_ff <= nxt_hold_data;
            rx_done_ff <= nxt_rx_done;
        end
    end

    tla_buf2 #(.W(CODE_W)) u_rx_buf (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(hold_valid_ff),
        .in_ready_out(buf_in_ready),
        .in_data_in(hold_data_ff),
        .out_valid_out(buf_out_valid),
        .out_ready_in(buf_pop),
        .out_data_out(buf_out_data)
    );

    // selection, input gate and status flags
    logic dev_ff, nxt_dev, gate_ff, nxt_gate, req_prev_ff, req_pend_ff, nxt_req_pend;
    logic fault_ff, nxt_fault, load_ff, nxt_load, service_request_flag_ff, nxt_service_request_flag;
    logic [CODE_W-1:0] in_data_ff, nxt_in_data;

    always_comb begin
        nxt_dev = comp_addr_in &&
            (select_char_in == ADDR_IO || select_char_in == ADDR_PUNCH); // [RULE_06]
        nxt_req_pend = req_pend_ff || (request_in && !req_prev_ff);
        buf_pop = req_pend_ff && buf_out_valid && !fault_ff; // [RULE_18]
        nxt_gate = buf_pop; // [RULE_12]
        nxt_in_data = buf_pop ? buf_out_data : in_data_ff; // [RULE_05]
        if (buf_pop) begin
            nxt_req_pend = request_in && !req_prev_ff;
        end
        nxt_fault = local_mode_in || (fault_ff && !status_reset_in); // [RULE_18] [RULE_14]
        nxt_load = (rx_done_ff && hold_data_ff == CODE_STX) ||
            (load_ff && !status_reset_in); // [RULE_14]
        nxt_service_request_flag = (rx_done_ff && hold_data_ff == CODE_ETX) ||
            (service_request_flag_ff && !status_reset_in && !service_request_clear_in); // [RULE_08]
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dev_ff <= 1'b0;
            gate_ff <= 1'b0;
            req_prev_ff <= 1'b0;
            req_pend_ff <= 1'b0;
            in_data_ff <= 7'h00;
            fault_ff <= 1'b0;
            load_ff <= 1'b0;
            service_request_flag_ff <= 1'b0;
        end else begin
            dev_ff <= nxt_dev;
            gate_ff <= nxt_gate;
            req_prev_ff <= request_in;
            req_pend_ff <= nxt_req_pend;
            in_data_ff <= nxt_in_data;
            fault_ff <= nxt_fault;
            load_ff <= nxt_load;
            service_request_flag_ff <= nxt_service_request_flag;
        end
    end

    // transmitter and write sequencing
    tla_tx_state_t tx_state_ff, nxt_tx_state;
    tla_src_t src_ff, nxt_src;
    logic [15:0] tx_cnt_ff, nxt_tx_cnt;
    logic [3:0] tx_bit_ff, nxt_tx_bit;
    logic [10:0] tx_sh_ff, nxt_tx_sh;
    logic [OUT_W-1:0] chr_ff, nxt_chr;
    logic chr_pend_ff, nxt_chr_pend, on_pend_ff, nxt_on_pend, off_pend_ff, nxt_off_pend;
    logic stat_pend_ff, nxt_stat_pend, discon_ff, nxt_discon, ack_ff, nxt_ack;
    logic stat_valid_ff, nxt_stat_valid, wr_prev_ff, st_prev_ff, ser_ff, nxt_ser;
    logic [CODE_W-1:0] stat_char_ff, nxt_stat_char;

    always_comb begin
        nxt_tx_state = tx_state_ff;
        nxt_src = src_ff;
        nxt_tx_cnt = 16'h0000;
        nxt_tx_bit = tx_bit_ff;
        nxt_tx_sh = tx_sh_ff;
        nxt_chr = chr_ff;
        nxt_chr_pend = chr_pend_ff;
        nxt_on_pend = on_pend_ff || (write_op_in && !wr_prev_ff); // [RULE_04]
        nxt_off_pend = off_pend_ff;
        nxt_stat_pend = stat_pend_ff;
        nxt_discon = discon_ff && !(write_op_in && !wr_prev_ff);
        nxt_ack = 1'b0;
        nxt_stat_valid = 1'b0;
        nxt_stat_char = stat_char_ff;
        if (status_req_in && !st_prev_ff) begin // [RULE_13]
            nxt_stat_pend = 1'b1;
            if (write_op_in) begin
                nxt_off_pend = 1'b1; // [RULE_19]
                nxt_discon = 1'b1;
            end
        end
        if (output_char_strobe_in && !discon_ff && !chr_pend_ff) begin
            nxt_chr = out_data_in; // [RULE_09] [RULE_01]
            nxt_chr_pend = 1'b1;
        end
        case (tx_state_ff)
            TX_IDLE: begin
                nxt_tx_bit = 4'h0;
                if (on_pend_ff) begin
                    nxt_src = SRC_ON;
                    nxt_tx_sh = {2'b11, CODE_PRN_ON, 1'b0};
                    nxt_tx_state = TX_SHIFT;
                end else if (chr_pend_ff) begin
                    nxt_src = SRC_DATA;
                    nxt_tx_sh = {2'b11, chr_ff, 1'b0}; // [RULE_02]
                    nxt_tx_state = TX_SHIFT;
                end else if (off_pend_ff) begin
                    nxt_src = SRC_OFF;
                    nxt_tx_sh = {2'b11, CODE_PRN_OFF, 1'b0};
                    nxt_tx_state = TX_SHIFT;
                end else if (stat_pend_ff) begin
                    nxt_stat_pend = 1'b0; // [RULE_19]
                    nxt_stat_valid = 1'b1;
                    nxt_stat_char = 7'h00;
                    nxt_stat_char[ST_FAULT] = fault_ff;
                    nxt_stat_char[ST_LOAD] = load_ff;
                    nxt_stat_char[ST_SERVICE_REQUEST_FLAG] = service_request_flag_ff;
                end
            end
            TX_SHIFT: begin
                nxt_tx_cnt = tx_cnt_ff + 16'h0001;
                if (tx_cnt_ff == BIT_DIV - 16'h0001) begin // [RULE_20]
                    nxt_tx_cnt = 16'h0000;
                    nxt_tx_sh = {1'b1, tx_sh_ff[10:1]};
                    nxt_tx_bit = tx_bit_ff + 4'h1;
                    if (tx_bit_ff == TX_LAST_BIT) begin
                        nxt_tx_state = TX_IDLE;
                        case (src_ff)
                            SRC_DATA: begin
                                nxt_chr_pend = 1'b0;
                                nxt_ack = 1'b1; // [RULE_10] [RULE_17]
                            end
                            SRC_ON: nxt_on_pend = write_op_in && !wr_prev_ff;
                            SRC_OFF: nxt_off_pend = status_req_in && !st_prev_ff && write_op_in;
                            default: nxt_on_pend = write_op_in && !wr_prev_ff;
                        endcase
                    end
                end
            end
            default: begin
                nxt_tx_state = TX_IDLE;
            end
        endcase
        nxt_ser = (nxt_tx_state == TX_SHIFT) ? nxt_tx_sh[0] : 1'b1; // [RULE_03]
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_state_ff <= TX_IDLE;
            src_ff <= SRC_DATA;
            tx_cnt_ff <= 16'h0000;
            tx_bit_ff <= 4'h0;
            tx_sh_ff <= 11'h7FF;
            chr_ff <= 8'h00;
            chr_pend_ff <= 1'b0;
            on_pend_ff <= 1'b0;
            off_pend_ff <= 1'b0;
            stat_pend_ff <= 1'b0;
            discon_ff <= 1'b0;
            ack_ff <= 1'b0;
            stat_valid_ff <= 1'b0;
            stat_char_ff <= 7'h00;
            wr_prev_ff <= 1'b0;
            st_prev_ff <= 1'b0;
            ser_ff <= 1'b1;
        end else begin
            tx_state_ff <= nxt_tx_state;
            src_ff <= nxt_src;
            tx_cnt_ff <= nxt_tx_cnt;
            tx_bit_ff <= nxt_tx_bit;
            tx_sh_ff <= nxt_tx_sh;
            chr_ff <= nxt_chr;
            chr_pend_ff <= nxt_chr_pend;
            on_pend_ff <= nxt_on_pend;
            off_pend_ff <= nxt_off_pend;
            stat_pend_ff <= nxt_stat_pend;
            discon_ff <= nxt_discon;
            ack_ff <= nxt_ack;
            stat_valid_ff <= nxt_stat_valid;
            stat_char_ff <= nxt_stat_char;
            wr_prev_ff <= write_op_in;
            st_prev_ff <= status_req_in;
            ser_ff <= nxt_ser;
        end
    end

    assign device_present_out = dev_ff;
    assign output_accept_ack_out = ack_ff;
    assign input_char_gate_out = gate_ff;
    assign in_data_out = in_data_ff;
    assign status_valid_out = stat_valid_ff;
    assign status_char_out = stat_char_ff;
    assign fault_out = fault_ff; // [RULE_15]
    assign load_out = load_ff;
    assign service_request_flag_out = service_request_flag_ff;
    assign serial_out = ser_ff;

    // checks
    sequence s_write_start;
        write_op_in && !wr_prev_ff;
    endsequence
    sequence s_tx_begin;
        tx_state_ff == TX_IDLE ##1 tx_state_ff == TX_SHIFT;
    endsequence

    dev_present_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_06]
        comp_addr_in && select_char_in == ADDR_IO |=> device_present_out)
        else $error("device present missing");
    prn_on_first_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_04]
        s_write_start |=> on_pend_ff) else $error("printer-on not queued");
    ack_after_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_17]
        $rose(output_accept_ack_out) |-> $past(tx_state_ff) == TX_SHIFT && $past(src_ff) == SRC_DATA)
        else $error("ack without finished shift");
    start_space_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_02]
        s_tx_begin |-> !serial_out) else $error("start space missing");
    stop_marks_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_02]
        tx_state_ff == TX_SHIFT && tx_bit_ff >= TX_STOP_BIT |-> serial_out)
        else $error("stop mark missing");
    service_request_flag_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_08]
        service_request_clear_in && !rx_done_ff |=> !service_request_flag_out)
        else $error("service request not cleared");
    status_reset_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_14]
        status_reset_in && !local_mode_in && !rx_done_ff |=> !fault_out && !load_out)
        else $error("status flags not cleared");
    fault_local_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_18]
        local_mode_in |=> fault_out ##1 !input_char_gate_out)
        else $error("local mode not blocking");
    input_gate_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_12]
        input_char_gate_out |-> $past(req_pend_ff) && !$past(fault_ff))
        else $error("input gate without request");
    status_order_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_19]
        status_valid_out |-> $past(tx_state_ff) == TX_IDLE && !$past(off_pend_ff)
        && !$past(chr_pend_ff)) else $error("status before register empty");
endmodule : tla_adapter
`default_nettype wire

// ===== verif/tla_far_model.sv
// line unit and terminal stand-in facing the adapter
`timescale 1ns/100ps
`default_nettype none
module tla_far_model (
    input wire logic clk_sys_in,
    input wire logic serial_out_in,
    output logic comp_addr_out,
    output logic [tla_pkg::CODE_W-1:0] select_char_out,
    output logic [3:0] lines_out,
    output logic [4:0] pulse_out,
    output logic [tla_pkg::OUT_W-1:0] out_data_out,
    output logic term_serial_out
);
    import tla_pkg::*;

    // line unit idle, terminal line at mark
    initial begin
        comp_addr_out = 1'b0;
        select_char_out = 7'h00;
        lines_out = 4'h0;
        pulse_out = 5'h00;
        out_data_out = 8'h00;
        term_serial_out = 1'b1;
    end

    // lines: local, control, read, write
    task automatic set_lines(input logic [3:0] v);
        @(posedge clk_sys_in);
        lines_out <= v;
    endtask : set_lines

    task automatic select(input logic [6:0] a, input logic on);
        @(posedge clk_sys_in);
        comp_addr_out <= on;
        select_char_out <= on ? a : ~select_char_out;
    endtask : select

    // one-cycle pulse; data only qualified with the strobe
    task automatic pulse(input int k, input logic [7:0] d);
        @(posedge clk_sys_in);
        pulse_out <= 5'(1 << k);
        out_data_out <= d;
        @(posedge clk_sys_in);
        pulse_out <= 5'h00;
        out_data_out <= ~d;
    endtask : pulse

    // terminal frame, pc is parity and code
    task automatic send(input logic [7:0] pc);
        logic [10:0] f;
        f = {2'b11, pc, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk_sys_in);
            term_serial_out <= f[i];
            repeat (BIT_DIV - 1) @(posedge clk_sys_in);
        end
    endtask : send

    // capture one frame, sampled mid-bit, returns at last stop
    task automatic get_frame(output logic [10:0] f);
        int n;
        f = 11'h000;
        n = 0;
        while (serial_out_in !== 1'b0 && n < 40000) begin
            @(negedge clk_sys_in);
            n++;
        end
        repeat (HALF_DIV) @(negedge clk_sys_in);
        for (int i = 0; i < 11; i++) begin
            f[i] = serial_out_in;
            if (i < 10) repeat (BIT_DIV) @(negedge clk_sys_in);
        end
    endtask : get_frame
endmodule : tla_far_model
`default_nettype wire

// ===== verif/tla_adapter_test.sv
// self-checking bench for the terminal line adapter
`timescale 1ns/100ps
`default_nettype none
module tla_adapter_test;
    import tla_pkg::*;
    localparam int P_CLR = 0;
    localparam int P_STB = 1;
    localparam int P_REQ = 2;
    localparam int P_STAT = 3;
    localparam int P_SRST = 4;
    logic clk_sys_in, rst_n_in, comp_addr, serial_in, serial_out;
    logic present, ack, gate, st_valid, fault, load, service_request_flag;
    logic [6:0] select_char, in_data, status_char, st_seen;
    logic [3:0] lines;
    logic [4:0] pulses;
    logic [7:0] out_data;
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;
    int evt_cnt [3] = '{0, 0, 0};

    tla_adapter i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .comp_addr_in(comp_addr), .select_char_in(select_char),
        .control_op_in(lines[2]), .read_op_in(lines[1]), .write_op_in(lines[0]),
        .service_request_clear_in(pulses[P_CLR]), .output_char_strobe_in(pulses[P_STB]),
        .out_data_in(out_data), .request_in(pulses[P_REQ]), .status_req_in(pulses[P_STAT]),
        .status_reset_in(pulses[P_SRST]), .local_mode_in(lines[3]), .serial_in(serial_in),
        .device_present_out(present), .output_accept_ack_out(ack),
        .input_char_gate_out(gate), .in_data_out(in_data), .status_valid_out(st_valid),
        .status_char_out(status_char), .fault_out(fault), .load_out(load),
        .service_request_flag_out(service_request_flag), .serial_out(serial_out));

    tla_far_model i_far (.clk_sys_in(clk_sys_in), .serial_out_in(serial_out),
        .comp_addr_out(comp_addr), .select_char_out(select_char), .lines_out(lines),
        .pulse_out(pulses), .out_data_out(out_data), .term_serial_out(serial_in));

    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end

    // event counters and hang guard
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (ack === 1'b1) evt_cnt[0] <= evt_cnt[0] + 1;
        if (gate === 1'b1) evt_cnt[1] <= evt_cnt[1] + 1;
        if (st_valid === 1'b1) begin
            evt_cnt[2] <= evt_cnt[2] + 1;
            st_seen <= status_char;
        end
        if (cycles == 95000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wait_evt(input int k, input int target, input int lim);
        for (int i = 0; i < lim && evt_cnt[k] < target; i++) @(negedge clk_sys_in);
    endtask : wait_evt

    task automatic t_select();
        logic [6:0] addr [3] = '{ADDR_IO, ADDR_PUNCH, 7'h45};
        for (int i = 0; i < 3; i++) begin
            i_far.select(addr[i], 1'b1);
            repeat (2) @(negedge clk_sys_in);
            check("device present", 11'(i < 2), 11'(present));
            i_far.select(7'h00, 1'b0);
            repeat (2) @(negedge clk_sys_in);
            check("present dropped", 11'h000, 11'(present));
        end
        i_far.pulse(P_SRST, 8'h00);
    endtask : t_select

    task automatic t_receive();
        i_far.set_lines(4'b0010);
        i_far.send({1'b1, CODE_STX});
        repeat (4) @(negedge clk_sys_in);
        check("load level", 11'h001, 11'(load));
        i_far.pulse(P_REQ, 8'h00);
        wait_evt(1, 1, 20);
        check("gate count", 11'h001, 11'(evt_cnt[1]));
        check("input char", 11'(CODE_STX), 11'(in_data));
        i_far.send({1'b0, CODE_ETX});
        repeat (4) @(negedge clk_sys_in);
        check("service level", 11'h001, 11'(service_request_flag));
        i_far.pulse(P_STAT, 8'h00);
        wait_evt(2, 1, 20);
        check("status char", 11'h006, 11'(st_seen));
        i_far.pulse(P_CLR, 8'h00);
        repeat (3) @(negedge clk_sys_in);
        check("load, service", 11'h002, 11'({load, service_request_flag}));
        i_far.set_lines(4'b1000);
        repeat (4) @(negedge clk_sys_in);
        check("fault in local", 11'h001, 11'(fault));
        i_far.pulse(P_SRST, 8'h00);
        i_far.pulse(P_REQ, 8'h00);
        repeat (30) @(negedge clk_sys_in);
        check("local flags", 11'h002, 11'({fault, load}));
        check("gate blocked", 11'h001, 11'(evt_cnt[1]));
        i_far.set_lines(4'b0000);
        i_far.pulse(P_SRST, 8'h00);
        repeat (3) @(negedge clk_sys_in);
        check("fault cleared", 11'h000, 11'(fault));
        i_far.pulse(P_REQ, 8'h00);
        wait_evt(1, 2, 30);
        check("gate count", 11'h002, 11'(evt_cnt[1]));
        check("input char", 11'(CODE_ETX), 11'(in_data));
    endtask : t_receive

    task automatic t_write();
        logic [10:0] f;
        i_far.set_lines(4'b0001);
        repeat (3) @(posedge clk_sys_in);
        i_far.pulse(P_STB, 8'hC5);
        i_far.get_frame(f);
        check("printer-on frame", {2'b11, CODE_PRN_ON, 1'b0}, f);
        check("ack early", 11'h000, 11'(evt_cnt[0]));
        i_far.get_frame(f);
        check("data frame", {2'b11, 8'hC5, 1'b0}, f);
        wait_evt(0, 1, 1200);
        check("ack count", 11'h001, 11'(evt_cnt[0]));
        i_far.pulse(P_STAT, 8'h00);
        i_far.get_frame(f);
        check("printer-off frame", {2'b11, CODE_PRN_OFF, 1'b0}, f);
        check("status held", 11'h001, 11'(evt_cnt[2]));
        wait_evt(2, 2, 1200);
        check("status count", 11'h002, 11'(evt_cnt[2]));
        check("status char", 11'h000, 11'(st_seen));
        i_far.set_lines(4'b0000);
        repeat (4) @(posedge clk_sys_in);
        i_far.set_lines(4'b0101);
        i_far.get_frame(f);
        check("printer-on again", {2'b11, CODE_PRN_ON, 1'b0}, f);
        i_far.set_lines(4'b0000);
    endtask : t_write

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        rst_n_in = 1'b0;
        repeat (5) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        check("reset outputs", 11'h001,
            11'({present, ack, gate, st_valid, fault, load, service_request_flag, serial_out}));
        @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        t_select();
        t_receive();
        t_write();
        report_and_stop();
    end
endmodule : tla_adapter_test
`default_nettype wire
